// ===== rtl/vttc_pkg.sv
// shared constants and carrier types for the vlan tag table control block
package vttc_pkg;

    // register byte offsets
    localparam logic [7:0] VTTC_OFF_CTRL     = 8'h00; // enables
    localparam logic [7:0] VTTC_OFF_VMAP     = 8'h04; // entry valid map
    localparam logic [7:0] VTTC_OFF_ACC_CNT  = 8'h08; // accepted tagged frames
    localparam logic [7:0] VTTC_OFF_DIS_CNT  = 8'h0c; // discarded tagged frames
    localparam logic [7:0] VTTC_OFF_CMD      = 8'hc0; // table command, write only
    localparam logic [7:0] VTTC_OFF_RSVD_A   = 8'hc4; // reserved slot a
    localparam logic [7:0] VTTC_OFF_RSVD_B   = 8'hc8; // reserved slot b

    // command register field positions
    localparam int VTTC_CMD_VID_LSB  = 0;  // identifier field low bit
    localparam int VTTC_CMD_VID_W    = 12; // identifier width
    localparam int VTTC_CMD_PRIO_LSB = 13; // priority field low bit
    localparam int VTTC_CMD_PRIO_W   = 3;  // priority width
    localparam int VTTC_CMD_IDX_LSB  = 16; // index field low bit
    localparam int VTTC_CMD_IDX_W    = 4;  // index width
    localparam int VTTC_CMD_ADD_BIT  = 21; // add when set, delete when clear
    localparam int VTTC_CMD_STRB     = 2;  // byte lane holding index/command

    // control register field positions
    localparam int VTTC_CTRL_TAG_EN  = 0;  // tag handling enable
    localparam int VTTC_CTRL_FILT_EN = 1;  // table filter enable

    // table geometry and reset values
    localparam int          VTTC_ENTRIES   = 16;    // table depth
    localparam int          VTTC_GLOBAL    = 0;     // global entry index
    localparam logic [31:0] VTTC_RST_WORD  = 32'h0; // register reset value

    // axi response codes
    localparam logic [1:0] VTTC_RESP_OKAY   = 2'h0; // accepted
    localparam logic [1:0] VTTC_RESP_SLVERR = 2'h2; // unmapped address

    // tag control information as carried in a tag header
    typedef struct packed {
        logic [2:0]  prio; // user priority
        logic        cfi;  // canonical format bit
        logic [11:0] vid;  // identifier
    } vttc_tci_type;

    // one table entry
    typedef struct packed {
        logic        valid; // entry holds an added tag
        logic [2:0]  prio;  // stored user priority
        logic [11:0] vid;   // stored identifier
    } vttc_entry_type;

endpackage : vttc_pkg

// ===== rtl/vttc_top.sv
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/10ps
`default_nettype none

module vttc_top
    import vttc_pkg::*;
#(
    parameter int ADDR_WIDTH = 8,  // axi address width
    parameter int CNT_WIDTH  = 32  // statistic counter width
) (
    // clock and reset
    input  wire  logic                    clk,
    input  wire  logic                    rst_n,
    // axi4-lite write address
    input  wire  logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
    input  wire  logic                    s_axi_awvalid,
    output var   logic                    s_axi_awready,
    // axi4-lite write data
    input  wire  logic [31:0]             s_axi_wdata,
    input  wire  logic [3:0]              s_axi_wstrb,
    input  wire  logic                    s_axi_wvalid,
    output var   logic                    s_axi_wready,
    // axi4-lite write response
    output var   logic [1:0]              s_axi_bresp,
    output var   logic                    s_axi_bvalid,
    input  wire  logic                    s_axi_bready,
    // axi4-lite read address
    input  wire  logic [ADDR_WIDTH-1:0]   s_axi_araddr,
    input  wire  logic                    s_axi_arvalid,
    output var   logic                    s_axi_arready,
    // axi4-lite read data
    output var   logic [31:0]             s_axi_rdata,
    output var   logic [1:0]              s_axi_rresp,
    output var   logic                    s_axi_rvalid,
    input  wire  logic                    s_axi_rready,
    // receive path tag check
    input  wire  logic                    rx_tag_valid,
    input  wire  vttc_pkg::vttc_tci_type  rx_tag_tci,
    output var   logic                    rx_frame_accept,
    output var   logic                    rx_frame_discard,
    // transmit path tag build
    input  wire  logic                    tx_insert_req,
    input  wire  logic [3:0]              tx_insert_index,
    output var   vttc_pkg::vttc_tci_type  tx_tag_tci,
    output var   logic                    tx_tag_valid,
    output var   logic                    tx_tag_hit
);
    import vttc_pkg::*;

    // refuse geometries the decode and counters cannot serve
    if (ADDR_WIDTH < 8) begin : g_chk_addr
        $error("vttc_top: ADDR_WIDTH must be at least 8");
    end
    if (CNT_WIDTH < 1 || CNT_WIDTH > 32) begin : g_chk_cnt
        $error("vttc_top: CNT_WIDTH must be 1 to 32");
    end

    // write channel holding state
    logic                  aw_held_reg;   // write address captured
    logic                  w_held_reg;    // write data captured
    logic [ADDR_WIDTH-1:0] wr_addr_reg;   // captured write address
    logic [31:0]           wr_data_reg;   // captured write data
    logic [3:0]            wr_strb_reg;   // captured byte enables

    // block state
    vttc_entry_type        table_reg [VTTC_ENTRIES]; // tag table
    logic                  tag_en_reg;     // tag handling enable
    logic                  filt_en_reg;    // table filter enable
    logic [CNT_WIDTH-1:0]  acc_cnt_reg;    // accepted count, saturating
    logic [CNT_WIDTH-1:0]  dis_cnt_reg;    // discarded count, saturating

    // write decode
    wire wr_go     = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    wire wr_is_ctl = wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_CTRL);
    wire wr_is_cmd = wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_CMD);
    wire wr_mapped = wr_is_ctl | wr_is_cmd
                   | (wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_VMAP))
                   | (wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_ACC_CNT))
                   | (wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_DIS_CNT))
                   | (wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_RSVD_A))
                   | (wr_addr_reg == ADDR_WIDTH'(VTTC_OFF_RSVD_B));

    // command fields, taken straight from the captured word
    wire        cmd_fire = wr_go & wr_is_cmd & wr_strb_reg[VTTC_CMD_STRB];
    wire [11:0] cmd_vid  = wr_data_reg[VTTC_CMD_VID_LSB +: VTTC_CMD_VID_W];
    wire [2:0]  cmd_prio = wr_data_reg[VTTC_CMD_PRIO_LSB +: VTTC_CMD_PRIO_W];
    wire [3:0]  cmd_idx  = wr_data_reg[VTTC_CMD_IDX_LSB +: VTTC_CMD_IDX_W];
    wire        cmd_add  = wr_data_reg[VTTC_CMD_ADD_BIT];
    wire        ctl_fire = wr_go & wr_is_ctl & wr_strb_reg[0];

    // per-entry match against the received tag
    logic [VTTC_ENTRIES-1:0] entry_match;  // entry accepts this tag
    logic [VTTC_ENTRIES-1:0] entry_valid;  // valid map for software
    for (genvar i = 0; i < VTTC_ENTRIES; i++) begin : g_match
        if (i == VTTC_GLOBAL) begin : g_global
            // global entry, once added, accepts every tagged frame
            assign entry_match[i] = table_reg[i].valid;
        end else begin : g_vlan
            // per-vlan entry matches identifier and priority
            assign entry_match[i] = table_reg[i].valid
                                  & (table_reg[i].vid == rx_tag_tci.vid)
                                  & (table_reg[i].prio == rx_tag_tci.prio);
        end
        assign entry_valid[i] = table_reg[i].valid;
    end

    // receive decision
    wire any_match  = |entry_match;
    wire filter_on  = tag_en_reg & filt_en_reg;
    wire rx_discard = rx_tag_valid & filter_on & ~any_match;
    wire rx_accept  = rx_tag_valid & ~rx_discard;

    // transmit entry selection
    vttc_entry_type tx_sel;  // entry chosen for insertion
    assign tx_sel = table_reg[tx_insert_index];

    // read decode
    logic [31:0] rd_word;    // data for the offered read address
    logic        rd_mapped;  // offered read address is a register
    always_comb begin
        rd_word   = VTTC_RST_WORD;
        rd_mapped = 1'b1;
        case (s_axi_araddr)
            ADDR_WIDTH'(VTTC_OFF_CTRL): begin
                rd_word[VTTC_CTRL_TAG_EN]  = tag_en_reg;
                rd_word[VTTC_CTRL_FILT_EN] = filt_en_reg;
            end
            ADDR_WIDTH'(VTTC_OFF_VMAP): begin
                rd_word[VTTC_ENTRIES-1:0] = entry_valid;
            end
            ADDR_WIDTH'(VTTC_OFF_ACC_CNT): begin
                rd_word[CNT_WIDTH-1:0] = acc_cnt_reg;
            end
            ADDR_WIDTH'(VTTC_OFF_DIS_CNT): begin
                rd_word[CNT_WIDTH-1:0] = dis_cnt_reg;
            end
            // command reads as zero, reserved slots read as zero
            ADDR_WIDTH'(VTTC_OFF_CMD): begin
                rd_word = VTTC_RST_WORD;
            end
            ADDR_WIDTH'(VTTC_OFF_RSVD_A),
            ADDR_WIDTH'(VTTC_OFF_RSVD_B): begin
                rd_word = VTTC_RST_WORD;
            end
            default: begin
                rd_mapped = 1'b0;
            end
        endcase
    end

    // write address and data capture, response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            wr_addr_reg   <= '0;
            wr_data_reg   <= VTTC_RST_WORD;
            wr_strb_reg   <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= VTTC_RESP_OKAY;
        end else begin
            // ready again once nothing is held
            s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                wr_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg  <= 1'b1;
                wr_data_reg <= s_axi_wdata;
                wr_strb_reg <= s_axi_wstrb;
            end
            // both halves held: act and answer on this edge
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_mapped ? VTTC_RESP_OKAY : VTTC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
            end
        end
    end

    // read address and data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= VTTC_RST_WORD;
            s_axi_rresp   <= VTTC_RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= rd_word;
                s_axi_rresp   <= rd_mapped ? VTTC_RESP_OKAY : VTTC_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end else if (!s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // control register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tag_en_reg  <= 1'b0;
            filt_en_reg <= 1'b0;
        end else if (ctl_fire) begin
            tag_en_reg  <= wr_data_reg[VTTC_CTRL_TAG_EN];
            filt_en_reg <= wr_data_reg[VTTC_CTRL_FILT_EN];
        end
    end

    // table add and delete, on the same edge that raises the write response
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int e = 0; e < VTTC_ENTRIES; e++) begin
                table_reg[e] <= '0;
            end
        end else if (cmd_fire) begin
            if (cmd_add) begin
                table_reg[cmd_idx] <= '{1'b1, cmd_prio, cmd_vid};
            end else begin
                table_reg[cmd_idx] <= '0;
            end
        end
    end

    // receive verdict and saturating statistics
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_frame_accept  <= 1'b0;
            rx_frame_discard <= 1'b0;
            acc_cnt_reg      <= '0;
            dis_cnt_reg      <= '0;
        end else begin
            rx_frame_accept  <= rx_accept;
            rx_frame_discard <= rx_discard;
            if (rx_accept && !(&acc_cnt_reg)) begin
                acc_cnt_reg <= acc_cnt_reg + 1'b1;
            end
            if (rx_discard && !(&dis_cnt_reg)) begin
                dis_cnt_reg <= dis_cnt_reg + 1'b1;
            end
        end
    end

    // transmit tag header build
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_tag_tci   <= '0;
            tx_tag_valid <= 1'b0;
            tx_tag_hit   <= 1'b0;
        end else begin
            tx_tag_valid <= tx_insert_req;
            if (tx_insert_req) begin
                tx_tag_tci <= '{tx_sel.prio, 1'b0, tx_sel.vid};
                tx_tag_hit <= tx_sel.valid;
            end
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    vttc_entry_type entry_zero;  // global entry, watched by checks
    assign entry_zero = table_reg[VTTC_GLOBAL];
    wire [11:0] tx_sel_vid  = tx_sel.vid;
    wire [2:0]  tx_sel_prio = tx_sel.prio;

    sequence s_cmd_taken;
        wr_go && wr_is_cmd && wr_strb_reg[VTTC_CMD_STRB];
    endsequence
    sequence s_add_seen;
        s_axi_bvalid && entry_valid[$past(cmd_idx)];
    endsequence

    a_tx_vid_build: assert property (tx_insert_req && !cmd_fire |=>
        tx_tag_valid && tx_tag_tci.vid == $past(tx_sel_vid))
        else $error("inserted identifier differs from entry");
    a_tx_prio_build: assert property (tx_insert_req && !cmd_fire |=>
        tx_tag_tci.prio == $past(tx_sel_prio) && tx_tag_tci.cfi == 1'b0)
        else $error("inserted priority differs from entry");
    a_index_only_one: assert property (cmd_fire && cmd_idx != 4'h0 |=>
        $stable(entry_zero))
        else $error("command touched an entry it did not index");
    a_global_accepts: assert property (rx_tag_valid && entry_zero.valid
        |=> rx_frame_accept && !rx_frame_discard)
        else $error("global entry failed to accept tagged frame");
    a_add_stores: assert property (s_cmd_taken ##0 cmd_add |=>
        table_reg[$past(cmd_idx)].vid == $past(cmd_vid)
        && table_reg[$past(cmd_idx)].prio == $past(cmd_prio))
        else $error("add did not store identifier and priority");
    a_delete_clears: assert property (s_cmd_taken ##0 !cmd_add |=>
        !entry_valid[$past(cmd_idx)])
        else $error("delete left entry valid");
    a_cmd_reads_zero: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ADDR_WIDTH'(VTTC_OFF_CMD)
        |=> s_axi_rvalid && s_axi_rdata == 32'h0)
        else $error("command register did not read as zero");
    a_discard_counted: assert property (rx_discard |=> rx_frame_discard
        && (dis_cnt_reg == $past(dis_cnt_reg) + 1'b1 || &$past(dis_cnt_reg)))
        else $error("unmatched tagged frame not discarded and counted");
    a_update_next: assert property (s_cmd_taken ##0 cmd_add |=>
        s_add_seen)
        else $error("table not updated with the write response");

endmodule : vttc_top

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    import vttc_pkg::*;

    // clock, reset and bus drive
    logic               clk;
    logic               rst_n;
    logic [7:0]         awaddr;
    logic               awvalid;
    logic               awready;
    logic [31:0]        wdata;
    logic [3:0]         wstrb;
    logic               wvalid;
    logic               wready;
    logic [1:0]         bresp;
    logic               bvalid;
    logic               bready;
    logic [7:0]         araddr;
    logic               arvalid;
    logic               arready;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               rvalid;
    logic               rready;
    // receive and transmit side
    logic               rx_tag_valid;
    vttc_tci_type       rx_tag_tci;
    logic               rx_frame_accept;
    logic               rx_frame_discard;
    logic               tx_insert_req;
    logic [3:0]         tx_insert_index;
    vttc_tci_type       tx_tag_tci;
    logic               tx_tag_valid;
    logic               tx_tag_hit;
    // bookkeeping
    int                 err_count;
    int                 tests_run;
    logic [31:0]        d;
    logic [1:0]         r;

    // tiny counters so saturation shows after three frames
    vttc_top #(.ADDR_WIDTH(8), .CNT_WIDTH(2)) i_vttc_top (
        .clk(clk), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_tag_valid(rx_tag_valid),
        .rx_tag_tci(rx_tag_tci), .rx_frame_accept(rx_frame_accept),
        .rx_frame_discard(rx_frame_discard),
        .tx_insert_req(tx_insert_req), .tx_insert_index(tx_insert_index),
        .tx_tag_tci(tx_tag_tci), .tx_tag_valid(tx_tag_valid),
        .tx_tag_hit(tx_tag_hit)
    );

    // 50 ns clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // compare and count, report at once
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // counts then verdict, the only exit
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // one write, waits for the response; only the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] dt,
                      input logic [3:0] s, output logic [1:0] rs);
        @(posedge clk);
        awaddr <= a; wdata <= dt; wstrb <= s;
        awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask

    // one read, waits for the data; only the watchdog ends a hang
    task automatic rd(input logic [7:0] a, output logic [31:0] dt,
                      output logic [1:0] rs);
        @(posedge clk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        dt = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    // command word: add flag, index, priority, identifier
    function automatic logic [31:0] cw(input logic ad, input logic [3:0] ix,
                                       input logic [2:0] p,
                                       input logic [11:0] v);
        cw = {10'h000, ad, 1'b0, ix, p, 1'b0, v};
    endfunction

    // one tag offered, verdict one cycle later
    task automatic rx_send(input logic [15:0] t, input logic acc);
        @(posedge clk);
        rx_tag_valid <= 1'b1;
        rx_tag_tci   <= vttc_tci_type'(t);
        @(posedge clk);
        rx_tag_valid <= 1'b0;
        #1;
        chk("rx accept", 32'(rx_frame_accept), 32'(acc));
        chk("rx discard", 32'(rx_frame_discard), 32'(!acc));
    endtask

    // one insertion request, built tag one cycle later
    task automatic tx_get(input logic [3:0] ix, input logic [15:0] t,
                          input logic hit);
        @(posedge clk);
        tx_insert_req   <= 1'b1;
        tx_insert_index <= ix;
        @(posedge clk);
        tx_insert_req <= 1'b0;
        #1;
        chk("tx valid", 32'(tx_tag_valid), 32'h1);
        chk("tx tci", 32'(tx_tag_tci), 32'(t));
        chk("tx hit", 32'(tx_tag_hit), 32'(hit));
    endtask

    // reset values, write-only and reserved places, unmapped address
    task automatic t_regs();
        logic [7:0] offs [7];
        offs = '{VTTC_OFF_CTRL, VTTC_OFF_VMAP, VTTC_OFF_ACC_CNT,
                 VTTC_OFF_DIS_CNT, VTTC_OFF_CMD, VTTC_OFF_RSVD_A,
                 VTTC_OFF_RSVD_B};
        foreach (offs[i]) begin
            rd(offs[i], d, r);
            chk("reset word", d, VTTC_RST_WORD);
            chk("reset read resp", 32'(r), 32'(VTTC_RESP_OKAY));
        end
        wr(VTTC_OFF_CMD, cw(1'b1, 4'h2, 3'h1, 12'h123), 4'hf, r);
        chk("cmd write resp", 32'(r), 32'(VTTC_RESP_OKAY));
        rd(VTTC_OFF_CMD, d, r);
        chk("cmd reads zero", d, 32'h0);
        rd(VTTC_OFF_VMAP, d, r);
        chk("map after add 2", d, 32'h00000004);
        wr(VTTC_OFF_RSVD_A, 32'hffffffff, 4'hf, r);
        chk("rsvd write resp", 32'(r), 32'(VTTC_RESP_OKAY));
        rd(VTTC_OFF_RSVD_A, d, r);
        chk("rsvd reads zero", d, 32'h0);
        rd(8'h10, d, r);
        chk("unmapped resp", 32'(r), 32'(VTTC_RESP_SLVERR));
        wr(8'h10, 32'h00000001, 4'hf, r);
        chk("unmapped write resp", 32'(r), 32'(VTTC_RESP_SLVERR));
        wr(VTTC_OFF_CMD, cw(1'b0, 4'h2, 3'h0, 12'h000), 4'hf, r);
        rd(VTTC_OFF_VMAP, d, r);
        chk("map after delete 2", d, 32'h00000000);
        $display("test regs done");
    endtask

    // adds at the index bounds, reserved bits ignored, lane check
    task automatic t_table();
        wr(VTTC_OFF_CMD, cw(1'b1, 4'hf, 3'h7, 12'hfff) | 32'hffd01000,
           4'hf, r);
        rd(VTTC_OFF_VMAP, d, r);
        chk("map after add 15", d, 32'h00008000);
        tx_get(4'hf, 16'hefff, 1'b1);
        wr(VTTC_OFF_CMD, cw(1'b1, 4'h0, 3'h2, 12'h001), 4'hf, r);
        tx_get(4'h0, 16'h4001, 1'b1);
        tx_get(4'h3, 16'h0000, 1'b0);
        wr(VTTC_OFF_CMD, cw(1'b1, 4'h5, 3'h5, 12'habc), 4'hb, r);
        rd(VTTC_OFF_VMAP, d, r);
        chk("map lane gated", d, 32'h00008001);
        $display("test table done");
    endtask

    // filtering, counters, global entry, delete then next frame
    task automatic t_filter();
        wr(VTTC_OFF_CMD, cw(1'b0, 4'h0, 3'h0, 12'h000), 4'hf, r);
        wr(VTTC_OFF_CTRL, 32'h3, 4'hf, r);
        wr(VTTC_OFF_CMD, cw(1'b1, 4'h5, 3'h5, 12'habc), 4'hf, r);
        rx_send(16'habc | 16'ha000, 1'b1);
        rx_send(16'h8abc, 1'b0);
        rx_send(16'haabd, 1'b0);
        rx_send(16'h0000, 1'b0);
        rx_send(16'h0001, 1'b0);
        rd(VTTC_OFF_DIS_CNT, d, r);
        chk("discard saturates", d, 32'h3);
        wr(VTTC_OFF_CTRL, 32'h1, 4'hf, r);
        rx_send(16'h0123, 1'b1);
        wr(VTTC_OFF_CTRL, 32'h2, 4'hf, r);
        rd(VTTC_OFF_CTRL, d, r);
        chk("ctrl filter only", d, 32'h2);
        rx_send(16'h0124, 1'b1);
        wr(VTTC_OFF_CTRL, 32'h3, 4'hf, r);
        wr(VTTC_OFF_CMD, cw(1'b1, 4'h0, 3'h0, 12'h000), 4'hf, r);
        rx_send(16'h0777, 1'b1);
        rd(VTTC_OFF_ACC_CNT, d, r);
        chk("accept count saturates", d, 32'h3);
        wr(VTTC_OFF_CMD, cw(1'b0, 4'h0, 3'h0, 12'h000), 4'hf, r);
        wr(VTTC_OFF_CMD, cw(1'b0, 4'h5, 3'h5, 12'habc), 4'hf, r);
        rx_send(16'haabc, 1'b0);
        tx_get(4'h5, 16'h0000, 1'b0);
        rd(VTTC_OFF_VMAP, d, r);
        chk("map after deletes", d, 32'h00008000);
        $display("test filter done");
    endtask

    // main sequence
    initial begin
        err_count = 0; tests_run = 0; rst_n = 1'b0;
        awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0;
        wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0;
        rready = 1'b0; rx_tag_valid = 1'b0; rx_tag_tci = '0;
        tx_insert_req = 1'b0; tx_insert_index = 4'h0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_table();
        t_filter();
        conclude();
    end

    // hang guard, far beyond the about 150 cycles needed
    initial begin
        #250000;
        err_count++;
        conclude();
    end

endmodule // tb

`default_nettype wire
